// [verilog/psl_pkg.sv]
// Package of constants and types for the strap configuration latch
// Contract
// - Every strap pin is captured around hardware reset and sets the configuration with no register writes.
// - Neither a software reset nor the power-down pin causes the straps to be sampled again.
// - A first interface-select strap of 0 selects MII mode whatever the second strap reads.
// - Interface straps 1 and 0 select RMII mode, and the pair 1 and 1 is reserved.
// - Unconnected interface straps read as 0 and therefore select MII mode.
// - A low negotiation-enable strap turns negotiation off and forces speed and duplex from the straps.
// - Forced straps 00, 01, 10 and 11 give 10M half, 10M full, 100M half and 100M full, speed first.
// - Negotiation advertises 10M half and full for 00, 100M both for 01, half only for 10, all for 11.
// - The sampled negotiation straps become the reset contents of the control and advertisement registers.
// - The negotiation and capability straps pull up, so the default pattern 111 advertises every ability.
// - Address bit 0 pulls up and bits 4 to 1 pull down, so an unconnected set gives address 1.
// - Grounded signal-detect inputs select copper; low positive over non-ground negative is fibre, no data.
// - A high positive with a low or mid negative input gives fibre with valid data; all else is undefined.
// - While the latched negotiation enable is set, the latched speed and duplex bits 13 and 8 are ignored.
package psl_pkg;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int unsigned CLK_PERIOD_NS    = 20;
   localparam int unsigned SYNC_STAGES      = 3;
   localparam logic [2:0]  STRAP_SETTLE     = 3'(SYNC_STAGES) + 3'h1;

   // ----------------------------------------
   // Register offsets and fields
   // ----------------------------------------
   localparam logic [11:0] ADDR_CTRL        = 12'h000;
   localparam logic [11:0] ADDR_ADV         = 12'h004;
   localparam logic [11:0] ADDR_RXMODE      = 12'h008;
   localparam logic [11:0] ADDR_STATUS      = 12'h00c;
   localparam logic [11:0] ADDR_CMD         = 12'h010;
   localparam int unsigned CTRL_LOOP_BIT    = 14;
   localparam int unsigned CTRL_SPEED_BIT   = 13;
   localparam int unsigned CTRL_NEG_BIT     = 12;
   localparam int unsigned CTRL_DUPLEX_BIT  = 8;
   localparam int unsigned ADV_10H_BIT      = 5;
   localparam int unsigned ADV_10F_BIT      = 6;
   localparam int unsigned ADV_100H_BIT     = 7;
   localparam int unsigned ADV_100F_BIT     = 8;
   localparam logic [15:0] ADV_SELECTOR     = 16'h0001;
   localparam int unsigned CMD_SOFT_RST_BIT = 0;
   localparam int unsigned CMD_PWRDN_BIT    = 1;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [15:0] CTRL_RESET       = 16'h3100;
   localparam logic [15:0] ADV_RESET        = 16'h01e1;
   localparam logic [4:0]  ADDR_RESET       = 5'h01;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {PSL_MII, PSL_RMII, PSL_IFACE_RSVD} psl_iface_type;
   typedef enum logic [1:0] {PSL_MEDIA_COPPER, PSL_MEDIA_FX_NODATA, PSL_MEDIA_FX_OK, PSL_MEDIA_UNDEF} psl_media_type;

   typedef struct packed {
      logic       loopback;
      logic       iface0;
      logic       iface1;
      logic       neg_enable;
      logic       speed_cap;
      logic       duplex_cap;
      logic [4:0] mgmt_addr;
   } psl_strap_type;

   typedef struct packed {
      logic [1:0] sig_detect_neg;
      logic [1:0] sig_detect_pos;
   } psl_sigdet_type;

   localparam logic [1:0] LVL_GND  = 2'h0;
   localparam logic [1:0] LVL_LOW  = 2'h1;
   localparam logic [1:0] LVL_MID  = 2'h2;
   localparam logic [1:0] LVL_HIGH = 2'h3;

endpackage : psl_pkg

// [verilog/psl_sync.sv]
// Three-stage synchroniser with agreement filter
`timescale 1ns/10ps
module psl_sync
#(
   parameter int unsigned WIDTH = 4
)
(
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   logic [WIDTH-1:0] next_dout;

   always_comb
   begin
      for (int i = 0; i < WIDTH; i++)
      begin
         next_dout[i] = (stage2[i] == stage3[i]) ? stage3[i] : dout[i];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
         dout   <= '0;
      end
      else
      begin
         stage1 <= din;
         stage2 <= stage1;
         stage3 <= stage2;
         dout   <= next_dout;
      end
   end

endmodule : psl_sync

// [verilog/psl_strap_latch.sv]
// Strap capture, configuration defaults and APB register access
`timescale 1ns/10ps
module psl_strap_latch
(
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [11:0]             paddr,
   input  wire logic [31:0]             pwdata,
   output logic      [31:0]             prdata,
   output logic                         pready,
   output logic                         pslverr,
   input  wire psl_pkg::psl_strap_type  strap_pins,
   input  wire psl_pkg::psl_sigdet_type sigdet,
   input  wire logic                    power_down_pin_n,
   output psl_pkg::psl_strap_type       strap_latched,
   output logic                         straps_valid,
   output psl_pkg::psl_iface_type       iface_mode,
   output psl_pkg::psl_media_type       media_mode,
   output logic                         neg_enable,
   output logic                         speed_100,
   output logic                         full_duplex,
   output logic                         loopback_en,
   output logic      [4:0]              mgmt_addr,
   output logic                         power_down
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   psl_pkg::psl_strap_type strap_q;
   logic                   captured;
   logic [15:0]            ctrl_reg;
   logic [15:0]            adv_reg;
   logic [4:0]             rxmode_reg;
   logic                   soft_rst;
   logic                   pwrdn_sw;
   psl_pkg::psl_strap_type next_strap_q;
   logic                   next_captured;
   logic [15:0]            next_ctrl_reg;
   logic [15:0]            next_adv_reg;
   logic [4:0]             next_rxmode_reg;
   logic                   next_soft_rst;
   logic                   next_pwrdn_sw;
   logic [15:0]            strap_ctrl;
   logic [15:0]            strap_adv;
   logic [31:0]            next_prdata;
   logic                   pd_sync;
   logic                   wr_en;
   logic                   rd_en;
   logic                   addr_ok;
   logic [2:0]             settle_cnt;
   logic [2:0]             next_settle_cnt;
   psl_pkg::psl_strap_type strap_sync;
   psl_pkg::psl_sigdet_type sigdet_sync;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   psl_sync #(.WIDTH(1)) u_pd_sync
   (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (~power_down_pin_n),
      .dout    (pd_sync)
   );

   psl_sync #(.WIDTH($bits(psl_pkg::psl_strap_type))) u_strap_sync
   (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (strap_pins),
      .dout    (strap_sync)
   );

   psl_sync #(.WIDTH($bits(psl_pkg::psl_sigdet_type))) u_sigdet_sync
   (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (sigdet),
      .dout    (sigdet_sync)
   );

   // ----------------------------------------
   // Strap-derived defaults
   // ----------------------------------------
   always_comb
   begin
      strap_ctrl = '0;
      strap_ctrl[psl_pkg::CTRL_LOOP_BIT]   = strap_q.loopback;
      strap_ctrl[psl_pkg::CTRL_NEG_BIT]    = strap_q.neg_enable;
      strap_ctrl[psl_pkg::CTRL_SPEED_BIT]  = strap_q.speed_cap;
      strap_ctrl[psl_pkg::CTRL_DUPLEX_BIT] = strap_q.duplex_cap;
      strap_adv = psl_pkg::ADV_SELECTOR;
      if (strap_q.neg_enable)
      begin
         strap_adv[psl_pkg::ADV_10H_BIT]  = ~strap_q.duplex_cap | strap_q.speed_cap;
         strap_adv[psl_pkg::ADV_10F_BIT]  = ~strap_q.speed_cap & ~strap_q.duplex_cap
                                            | strap_q.speed_cap & strap_q.duplex_cap;
         strap_adv[psl_pkg::ADV_100H_BIT] = strap_q.duplex_cap | strap_q.speed_cap;
         strap_adv[psl_pkg::ADV_100F_BIT] = strap_q.duplex_cap;
      end
   end

   // ----------------------------------------
   // Capture and register state
   // ----------------------------------------
   assign wr_en   = psel & penable & pwrite;
   assign rd_en   = psel & ~pwrite;
   assign addr_ok = (paddr == psl_pkg::ADDR_CTRL) || (paddr == psl_pkg::ADDR_ADV) ||
                    (paddr == psl_pkg::ADDR_RXMODE) || (paddr == psl_pkg::ADDR_STATUS) ||
                    (paddr == psl_pkg::ADDR_CMD);

   always_comb
   begin
      next_strap_q    = strap_q;
      next_captured   = captured;
      next_settle_cnt = settle_cnt;
      next_ctrl_reg   = ctrl_reg;
      next_adv_reg    = adv_reg;
      next_rxmode_reg = rxmode_reg;
      next_soft_rst   = 1'b0;
      next_pwrdn_sw   = pwrdn_sw;
      if (settle_cnt != psl_pkg::STRAP_SETTLE)
      begin
         // Wait until the strap synchroniser agrees with the pins
         next_settle_cnt = settle_cnt + 3'h1;
      end
      else if (!captured)
      begin
         // Settled board ties are taken once per hardware reset
         next_strap_q  = strap_sync;
         next_captured = 1'b1;
      end
      if (captured && !straps_valid)
      begin
         next_ctrl_reg   = strap_ctrl;
         next_adv_reg    = strap_adv;
         next_rxmode_reg = strap_q.mgmt_addr;
      end
      else if (soft_rst)
      begin
         // Soft reset restores the latched control and advertisement defaults, but not the address, without resampling pins
         next_ctrl_reg = strap_ctrl;
         next_adv_reg  = strap_adv;
      end
      else if (wr_en && addr_ok)
      begin
         unique case (paddr)
            psl_pkg::ADDR_CTRL:   next_ctrl_reg   = pwdata[15:0];
            psl_pkg::ADDR_ADV:    next_adv_reg    = pwdata[15:0];
            psl_pkg::ADDR_RXMODE: next_rxmode_reg = pwdata[4:0];
            psl_pkg::ADDR_CMD:
            begin
               next_soft_rst = pwdata[psl_pkg::CMD_SOFT_RST_BIT];
               next_pwrdn_sw = pwdata[psl_pkg::CMD_PWRDN_BIT];
            end
            default: next_ctrl_reg = ctrl_reg;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         strap_q      <= '0;
         captured     <= 1'b0;
         settle_cnt   <= 3'h0;
         straps_valid <= 1'b0;
         ctrl_reg     <= psl_pkg::CTRL_RESET;
         adv_reg      <= psl_pkg::ADV_RESET;
         rxmode_reg   <= psl_pkg::ADDR_RESET;
         soft_rst     <= 1'b0;
         pwrdn_sw     <= 1'b0;
      end
      else
      begin
         strap_q    <= next_strap_q;
         captured   <= next_captured;
         settle_cnt <= next_settle_cnt;
         straps_valid <= captured;
         ctrl_reg   <= next_ctrl_reg;
         adv_reg    <= next_adv_reg;
         rxmode_reg <= next_rxmode_reg;
         soft_rst   <= next_soft_rst;
         pwrdn_sw   <= next_pwrdn_sw;
      end
   end

   // ----------------------------------------
   // Mode decode
   // ----------------------------------------
   always_comb
   begin
      if (!strap_q.iface0)
         iface_mode = psl_pkg::PSL_MII;
      else if (!strap_q.iface1)
         iface_mode = psl_pkg::PSL_RMII;
      else
         iface_mode = psl_pkg::PSL_IFACE_RSVD;
      if (sigdet_sync.sig_detect_neg == psl_pkg::LVL_GND && sigdet_sync.sig_detect_pos == psl_pkg::LVL_GND)
         media_mode = psl_pkg::PSL_MEDIA_COPPER;
      else if (sigdet_sync.sig_detect_pos == psl_pkg::LVL_LOW && sigdet_sync.sig_detect_neg != psl_pkg::LVL_GND)
         media_mode = psl_pkg::PSL_MEDIA_FX_NODATA;
      else if (sigdet_sync.sig_detect_pos == psl_pkg::LVL_HIGH &&
               (sigdet_sync.sig_detect_neg == psl_pkg::LVL_LOW || sigdet_sync.sig_detect_neg == psl_pkg::LVL_MID))
         media_mode = psl_pkg::PSL_MEDIA_FX_OK;
      else
         media_mode = psl_pkg::PSL_MEDIA_UNDEF;
   end

   assign strap_latched = strap_q;
   assign neg_enable    = ctrl_reg[psl_pkg::CTRL_NEG_BIT];
   // Negotiation on masks the forced speed and duplex bits
   assign speed_100     = ~neg_enable & ctrl_reg[psl_pkg::CTRL_SPEED_BIT];
   assign full_duplex   = ~neg_enable & ctrl_reg[psl_pkg::CTRL_DUPLEX_BIT];
   assign loopback_en   = ctrl_reg[psl_pkg::CTRL_LOOP_BIT];
   assign mgmt_addr     = rxmode_reg;
   assign power_down    = pd_sync | pwrdn_sw;

   // ----------------------------------------
   // APB read path
   // ----------------------------------------
   always_comb
   begin
      next_prdata = prdata;
      if (rd_en && !penable)
      begin
         next_prdata = '0;
         unique case (paddr)
            psl_pkg::ADDR_CTRL:   next_prdata[15:0] = ctrl_reg;
            psl_pkg::ADDR_ADV:    next_prdata[15:0] = adv_reg;
            psl_pkg::ADDR_RXMODE: next_prdata[4:0]  = rxmode_reg;
            psl_pkg::ADDR_STATUS: next_prdata[7:0]  = {straps_valid, power_down, media_mode,
                                                       iface_mode, soft_rst, pwrdn_sw};
            default:              next_prdata = '0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= '0;
      else
         prdata <= next_prdata;
   end

   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~addr_ok;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence strap_load_s;
      captured && !straps_valid;
   endsequence

   strap_once_a: assert property (@(posedge pclk) disable iff (!presetn)
      straps_valid |-> $stable(strap_q)) else $error("strap capture changed after latch");
   soft_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
      soft_rst |=> strap_q == $past(strap_q)) else $error("soft reset resampled straps");
   mii_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
      !strap_q.iface0 |-> iface_mode == psl_pkg::PSL_MII) else $error("mii not selected");
   rmii_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
      strap_q.iface0 && !strap_q.iface1 |-> iface_mode == psl_pkg::PSL_RMII) else $error("rmii not selected");
   ctrl_load_a: assert property (@(posedge pclk) disable iff (!presetn)
      strap_load_s |=> ctrl_reg[psl_pkg::CTRL_NEG_BIT] == strap_q.neg_enable) else $error("ctrl default wrong");
   adv_all_a: assert property (@(posedge pclk) disable iff (!presetn)
      strap_load_s ##0 (strap_q.neg_enable && strap_q.speed_cap && strap_q.duplex_cap)
      |=> adv_reg[8:5] == 4'hf) else $error("advertise all missing");
   addr_load_a: assert property (@(posedge pclk) disable iff (!presetn)
      strap_load_s |=> rxmode_reg == $past(strap_q.mgmt_addr)) else $error("address not latched");
   neg_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
      neg_enable |-> !speed_100 && !full_duplex) else $error("forced bits not masked");
   fx_ok_a: assert property (@(posedge pclk) disable iff (!presetn)
      sigdet_sync.sig_detect_pos == psl_pkg::LVL_HIGH && sigdet_sync.sig_detect_neg == psl_pkg::LVL_LOW
      |-> media_mode == psl_pkg::PSL_MEDIA_FX_OK) else $error("fibre link not good");
   valid_time_a: assert property (@(posedge pclk) disable iff (!presetn)
      strap_load_s |=> straps_valid) else $error("straps not marked valid");
   forced_speed_a: assert property (@(posedge pclk) disable iff (!presetn)
      strap_load_s |=> speed_100 == (!strap_q.neg_enable && strap_q.speed_cap)) else $error("forced speed wrong");
   copper_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
      sigdet_sync.sig_detect_neg == psl_pkg::LVL_GND && sigdet_sync.sig_detect_pos == psl_pkg::LVL_GND
      |-> media_mode == psl_pkg::PSL_MEDIA_COPPER) else $error("copper not selected");
   fx_nodata_a: assert property (@(posedge pclk) disable iff (!presetn)
      sigdet_sync.sig_detect_pos == psl_pkg::LVL_LOW && sigdet_sync.sig_detect_neg != psl_pkg::LVL_GND
      |-> media_mode == psl_pkg::PSL_MEDIA_FX_NODATA) else $error("fibre no data wrong");

endmodule : psl_strap_latch

// [sim/psl_board.sv]
// Board strap resistor model for the strap configuration latch
`timescale 1ns/10ps
module psl_board
(
   input  wire psl_pkg::psl_strap_type drive_en,
   input  wire psl_pkg::psl_strap_type drive_val,
   output psl_pkg::psl_strap_type      strap_pins
);

   // ----------------------------------------
   // Pull levels of unconnected pins
   // ----------------------------------------
   localparam logic [10:0] PULLS = 11'h0e1;

   // Resistor-tied pins win, open pins settle to their pull level
   assign strap_pins = (drive_en & drive_val) | (~drive_en & PULLS);

endmodule : psl_board

// [sim/phy_strap_config_latch_tb.sv]
// Self-checking testbench for the strap configuration latch
`timescale 1ns/10ps
module phy_strap_config_latch_tb;

   logic                    pclk             = 1'b0;
   logic                    presetn          = 1'b0;
   logic                    psel             = 1'b0;
   logic                    penable          = 1'b0;
   logic                    pwrite           = 1'b0;
   logic [11:0]             paddr            = 12'h000;
   logic [31:0]             pwdata           = 32'h0;
   logic                    power_down_pin_n = 1'b1;
   psl_pkg::psl_sigdet_type sigdet           = '0;
   psl_pkg::psl_strap_type  drv_en           = '0;
   psl_pkg::psl_strap_type  drv_val          = '0;
   psl_pkg::psl_strap_type  strap_pins, strap_latched, s;
   psl_pkg::psl_iface_type  iface_mode;
   psl_pkg::psl_media_type  media_mode, em;
   logic [31:0]             prdata, rd, rnd;
   logic [4:0]              mgmt_addr;
   logic                    pready, pslverr, err, straps_valid, neg_enable;
   logic                    speed_100, full_duplex, loopback_en, power_down;
   int                      errors     = 0;
   int                      n_compared = 0;
   int                      adv_tab[4] = '{32'h061, 32'h181, 32'h0a1, 32'h1e1};

   always #10 pclk = ~pclk;

   psl_board psl_board_inst (.drive_en(drv_en), .drive_val(drv_val), .strap_pins(strap_pins));

   psl_strap_latch psl_strap_latch_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .strap_pins(strap_pins), .sigdet(sigdet), .power_down_pin_n(power_down_pin_n),
      .strap_latched(strap_latched), .straps_valid(straps_valid), .iface_mode(iface_mode),
      .media_mode(media_mode), .neg_enable(neg_enable), .speed_100(speed_100), .full_duplex(full_duplex),
      .loopback_en(loopback_en), .mgmt_addr(mgmt_addr), .power_down(power_down));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : print_verdict

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp)
      begin
         errors++;
         $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk_val

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rdv, output logic e);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50)
      begin
         chk_val(1'b0, 1'b1, "pready timeout");
         print_verdict();
      end
      rdv = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic hw_reset(input logic [10:0] en, input logic [10:0] val);
      presetn <= 1'b0;
      drv_en <= en;
      drv_val <= val;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      repeat (7) @(posedge pclk);
   endtask : hw_reset

   task automatic check_config(input psl_pkg::psl_strap_type x);
      logic [1:0] ei;
      ei = !x.iface0 ? psl_pkg::PSL_MII : (x.iface1 ? psl_pkg::PSL_IFACE_RSVD : psl_pkg::PSL_RMII);
      chk_val(strap_latched, x, "latched");
      chk_val(straps_valid, 1'b1, "valid");
      chk_val(iface_mode, ei, "iface");
      chk_val(neg_enable, x.neg_enable, "neg");
      chk_val(speed_100, x.speed_cap & ~x.neg_enable, "speed");
      chk_val(full_duplex, x.duplex_cap & ~x.neg_enable, "duplex");
      chk_val(loopback_en, x.loopback, "loop");
      chk_val(mgmt_addr, x.mgmt_addr, "addr");
      apb(1'b0, psl_pkg::ADDR_CTRL, 32'h0, rd, err);
      chk_val(rd, {x.loopback, x.speed_cap, x.neg_enable, 3'h0, x.duplex_cap, 8'h00}, "ctrl");
      apb(1'b0, psl_pkg::ADDR_ADV, 32'h0, rd, err);
      if (x.neg_enable)
         chk_val(rd, adv_tab[{x.speed_cap, x.duplex_cap}], "adv");
      apb(1'b0, psl_pkg::ADDR_RXMODE, 32'h0, rd, err);
      chk_val(rd, x.mgmt_addr, "rxmode");
   endtask : check_config

   // ----------------------------------------
   // Watchdog
   // ----------------------------------------
   initial
   begin
      repeat (20000) @(posedge pclk);
      errors++;
      $display("FAIL %0t watchdog expired", $time);
      print_verdict();
   end

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial
   begin
      void'($urandom(32'h52d8fc47));
      hw_reset(11'h000, 11'h000);
      chk_val(iface_mode, psl_pkg::PSL_MII, "open iface");
      chk_val(mgmt_addr, 5'h01, "open addr");
      chk_val(loopback_en, 1'b0, "open loop");
      apb(1'b0, psl_pkg::ADDR_ADV, 32'h0, rd, err);
      chk_val(rd, 32'h1e1, "open adv");
      check_config(strap_pins);
      $display("test open_straps done");
      for (int i = 0; i < 32; i++)
      begin
         rnd = $urandom;
         hw_reset(rnd[31:21] | 11'h3e0, {rnd[10], i[4:0], rnd[4:0]});
         check_config(strap_pins);
      end
      $display("test strap_table done");
      hw_reset(11'h7ff, 11'h54a);
      s = strap_pins;
      drv_val <= 11'h2b5;
      apb(1'b1, psl_pkg::ADDR_CTRL, 32'h0, rd, err);
      apb(1'b0, psl_pkg::ADDR_CTRL, 32'h0, rd, err);
      chk_val(rd, 32'h0, "ctrl written");
      apb(1'b1, psl_pkg::ADDR_CMD, 32'h1, rd, err);
      repeat (2) @(posedge pclk);
      check_config(s);
      power_down_pin_n <= 1'b0;
      repeat (6) @(posedge pclk);
      chk_val(power_down, 1'b1, "pin power down");
      power_down_pin_n <= 1'b1;
      repeat (6) @(posedge pclk);
      chk_val(power_down, 1'b0, "pin power up");
      check_config(s);
      apb(1'b1, psl_pkg::ADDR_CMD, 32'h2, rd, err);
      chk_val(power_down, 1'b1, "sw power down");
      apb(1'b0, psl_pkg::ADDR_STATUS, 32'h0, rd, err);
      chk_val(rd, 32'hc1, "status");
      apb(1'b1, psl_pkg::ADDR_CMD, 32'h0, rd, err);
      chk_val(power_down, 1'b0, "sw power up");
      check_config(s);
      $display("test no_resample done");
      for (int i = 0; i < 16; i++)
      begin
         sigdet <= i[3:0];
         repeat (5) @(posedge pclk);
         if (i[1:0] == 0 && i[3:2] == 0)
            em = psl_pkg::PSL_MEDIA_COPPER;
         else if (i[1:0] == 1 && i[3:2] != 0)
            em = psl_pkg::PSL_MEDIA_FX_NODATA;
         else if (i[1:0] == 3 && (i[3:2] == 1 || i[3:2] == 2))
            em = psl_pkg::PSL_MEDIA_FX_OK;
         else
            em = psl_pkg::PSL_MEDIA_UNDEF;
         chk_val(media_mode, em, "media");
      end
      $display("test signal_detect done");
      apb(1'b0, 12'h020, 32'h0, rd, err);
      chk_val(err, 1'b1, "unmapped error");
      chk_val(rd, 32'h0, "unmapped data");
      $display("test unmapped done");
      print_verdict();
   end

endmodule : phy_strap_config_latch_tb
